// [shared/mp_pkg.sv]
// mp_pkg: constants and types shared by the memory access path
// assumes: one address unit is a 24-bit word; physical space is 2**20 units
package mp_pkg;
  localparam int WORD_W     = 48;
  localparam int HALF_W     = 24;
  localparam int ADDR_W     = 20;
  localparam int SEC_W      = 5;
  localparam int SEC_OFF_W  = 15;  // 96K bytes = 32K units
  localparam int PG_OFF_W   = 10;  // 3K bytes = 1K units
  localparam int FRAME_W    = ADDR_W - PG_OFF_W;
  localparam int CIDX_W     = 9;   // 512 words per cache section
  localparam int CTAG_W     = ADDR_W - 1 - CIDX_W;
  localparam int CENT_W     = 1 + CTAG_W + WORD_W;
  localparam int PTE_W      = 1 + FRAME_W;
  localparam int IB_DEPTH   = 4;
  localparam int INIT_CNT_W = 10;
  localparam logic [ADDR_W-1:0]     LIM_DIRECT   = 20'h08000;  // 96K bytes
  localparam logic [ADDR_W-1:0]     LIM_INDIRECT = 20'h40000;  // 768K bytes
  localparam logic [ADDR_W-1:0]     LIM_CODE     = 20'h10000;  // 192K bytes
  localparam logic [INIT_CNT_W-1:0] INIT_LAST    = 10'h3FF;
  typedef enum logic [1:0] {SRC_CPU, SRC_BLK, SRC_COMM} mp_src_t;
  typedef enum logic [1:0] {SZ_W48, SZ_W24, SZ_BYTE, SZ_BIT} mp_size_t;
  typedef enum logic {REF_DIRECT, REF_INDIRECT} mp_ref_t;
endpackage

// [rtl/mp_ram.sv]
// mp_ram: simple dual-port memory with registered read data
// assumes: contents are undefined until written by the owner
`timescale 1ns/10ps
`default_nettype none
module mp_ram
  import mp_pkg::*;
#(
  parameter int DW = CENT_W,
  parameter int AW = CIDX_W
) (
  input  wire logic          ref_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// [rtl/mp_agen.sv]
// mp_agen: forms the logical address and range error for one request
// assumes: load pulses once per accepted request; outputs hold until next load
`timescale 1ns/10ps
`default_nettype none
module mp_agen
  import mp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              load,
  input  wire mp_src_t           src,
  input  wire logic              instr,
  input  wire mp_ref_t           dref,
  input  wire logic              ext_mode,
  input  wire logic              vm_en,
  input  wire logic              user_mode,
  input  wire logic [SEC_W-1:0]  map,
  input  wire logic [ADDR_W-1:0] off,
  output logic      [ADDR_W-1:0] la,
  output logic                   err,
  output logic                   xlate
);
  typedef struct packed {
    logic [ADDR_W-1:0] la;
    logic              err;
    logic              xlate;
  } mp_agen_st_t;

  mp_agen_st_t       st_ff;
  mp_agen_st_t       nxt_st;
  logic [ADDR_W-1:0] base;

  always_comb begin
    nxt_st = st_ff;
    base   = {map, {SEC_OFF_W{1'b0}}};
    if (load) begin
      nxt_st.err   = 1'b0;
      nxt_st.xlate = vm_en && user_mode && (src == SRC_CPU);
      if (src != SRC_CPU || ext_mode) begin
        nxt_st.la = off;
      end else if (instr) begin
        nxt_st.la  = base + off;
        nxt_st.err = off >= LIM_CODE;
      end else if (dref == REF_DIRECT) begin
        nxt_st.la  = {map, off[SEC_OFF_W-1:0]};
        nxt_st.err = off >= LIM_DIRECT;
      end else begin
        nxt_st.la  = off;
        nxt_st.err = off >= LIM_INDIRECT;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign la    = st_ff.la;
  assign err   = st_ff.err;
  assign xlate = st_ff.xlate;

  a_direct_sect: assert property (@(posedge ref_clk) disable iff (rst)
    load && src == SRC_CPU && !ext_mode && !instr && dref == REF_DIRECT && off < LIM_DIRECT
    |=> !err && la[ADDR_W-1:SEC_OFF_W] == $past(map))
    else $error("direct address left its section");
  a_ext_full: assert property (@(posedge ref_clk) disable iff (rst)
    load && ext_mode |=> !err && la == $past(off))
    else $error("extension mode address altered or refused");
endmodule
`default_nettype wire

// [rtl/mp_mem_path.sv]
// mp_mem_path: memory access path with paging, split cache and memory handshake
// assumes: one requester at a time; memory decodes mem_addr itself and answers
// mem_ack for one cycle while mem_req is high
`timescale 1ns/10ps
`default_nettype none
module mp_mem_path
  import mp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              ext_mode,
  input  wire logic              vm_en,
  input  wire logic              user_mode,
  input  wire logic              req_valid,
  input  wire mp_src_t           req_src,
  input  wire logic              req_instr,
  input  wire mp_ref_t           req_ref,
  input  wire mp_size_t          req_size,
  input  wire logic              req_we,
  input  wire logic [SEC_W-1:0]  req_map,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [1:0]        req_bsel,
  input  wire logic [4:0]        req_bitn,
  input  wire logic [WORD_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic      [WORD_W-1:0] rsp_data,
  output logic                   rsp_fault,
  output logic                   rsp_range_err,
  input  wire logic              ib_pop,
  output logic                   ib_valid,
  output logic      [WORD_W-1:0] ib_data,
  output logic      [2:0]        ib_count,
  input  wire logic              pt_we,
  input  wire logic [FRAME_W-1:0] pt_page,
  input  wire logic [FRAME_W-1:0] pt_frame,
  input  wire logic              pt_present,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [WORD_W-1:0] mem_wdata,
  input  wire logic [WORD_W-1:0] mem_rdata,
  input  wire logic              mem_ack,
  input  wire logic              mem_busy
);
  typedef enum logic [2:0] {S_INIT, S_IDLE, S_AGEN, S_XLAT, S_LOOK, S_MRD, S_MWR} mp_state_t;

  typedef struct packed {
    mp_state_t                      fsm;
    logic [INIT_CNT_W-1:0]          icnt;
    logic                           instr;
    logic                           we;
    mp_size_t                       size;
    logic [1:0]                     bsel;
    logic [4:0]                     bitn;
    logic [WORD_W-1:0]              wd;
    logic [ADDR_W-1:0]              mar;
    logic [WORD_W-1:0]              mdr;
    logic                           mem_req;
    logic                           mem_we;
    logic                           ready;
    logic                           rsp_valid;
    logic [WORD_W-1:0]              rsp_data;
    logic                           rsp_fault;
    logic                           rsp_err;
    logic [IB_DEPTH-1:0][WORD_W-1:0] ib;
    logic [2:0]                     ib_cnt;
    logic                           ib_valid;
  } mp_st_t;

  mp_st_t            st_ff;
  mp_st_t            nxt_st;
  logic [ADDR_W-1:0] ag_la;
  logic              ag_err;
  logic              ag_xl;
  logic              acc;
  logic [ADDR_W-1:0] pa;
  logic [PTE_W-1:0]  pte;
  logic [CENT_W-1:0] ird;
  logic [CENT_W-1:0] ord;
  logic [CENT_W-1:0] ent;
  logic              hit;
  logic              init;
  logic              cwe;
  logic              cwe_i;
  logic              cwe_o;
  logic [WORD_W-1:0] cwdata;
  logic [CENT_W-1:0] cwent;
  logic [CIDX_W-1:0] cwaddr;
  logic              done;
  logic              fault;
  logic              rerr;
  logic              push;
  logic [WORD_W-1:0] dword;
  logic [2:0]        cnt;

  // selects the addressed 24-bit unit, byte or bit of a word
  function automatic logic [WORD_W-1:0] pick(logic [WORD_W-1:0] w, logic lo, mp_size_t sz,
                                              logic [1:0] bs, logic [4:0] bn);
    logic [HALF_W-1:0] h;
    h = lo ? w[HALF_W-1:0] : w[WORD_W-1:HALF_W];
    case (sz)
      SZ_W48:  pick = w;
      SZ_W24:  pick = {{HALF_W{1'b0}}, h};
      SZ_BYTE: pick = {{(WORD_W-8){1'b0}}, 8'(h >> (5'h10 - {bs, 3'h0}))};
      default: pick = {{(WORD_W-1){1'b0}}, 1'(h >> bn)};
    endcase
  endfunction

  // inserts store data into the fetched word
  function automatic logic [WORD_W-1:0] merge(logic [WORD_W-1:0] w, logic lo, mp_size_t sz,
                                               logic [1:0] bs, logic [4:0] bn, logic [WORD_W-1:0] d);
    logic [HALF_W-1:0] h;
    logic [HALF_W-1:0] m;
    logic [HALF_W-1:0] v;
    logic [4:0]        sh;
    h  = lo ? w[HALF_W-1:0] : w[WORD_W-1:HALF_W];
    sh = 5'h10 - {bs, 3'h0};
    m  = '1;
    v  = d[HALF_W-1:0];
    case (sz)
      SZ_BYTE: begin
        m = 24'h0000FF << sh;
        v = HALF_W'(d[7:0]) << sh;
      end
      SZ_BIT: begin
        m = 24'h000001 << bn;
        v = HALF_W'(d[0]) << bn;
      end
      default: ;
    endcase
    h = (h & ~m) | (v & m);
    if (sz == SZ_W48) begin
      merge = d;
    end else begin
      merge = lo ? {w[WORD_W-1:HALF_W], h} : {h, w[HALF_W-1:0]};
    end
  endfunction

  mp_agen u_agen (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .load      (acc),
    .src       (req_src),
    .instr     (req_instr),
    .dref      (req_ref),
    .ext_mode  (ext_mode),
    .vm_en     (vm_en),
    .user_mode (user_mode),
    .map       (req_map),
    .off       (req_addr),
    .la        (ag_la),
    .err       (ag_err),
    .xlate     (ag_xl)
  );

  // page table: present bit and frame per logical page
  mp_ram #(.DW(PTE_W), .AW(FRAME_W)) u_ptab (
    .ref_clk (ref_clk),
    .we      (init || pt_we),
    .waddr   (init ? st_ff.icnt : pt_page),
    .wdata   (init ? '0 : {pt_present, pt_frame}),
    .raddr   (ag_la[ADDR_W-1:PG_OFF_W]),
    .rdata   (pte)
  );

  // split cache sections read together, both cleared during init, otherwise written only for their own kind
  mp_ram #(.DW(CENT_W), .AW(CIDX_W)) u_icache (
    .ref_clk (ref_clk),
    .we      (cwe_i),
    .waddr   (cwaddr),
    .wdata   (cwent),
    .raddr   (pa[CIDX_W:1]),
    .rdata   (ird)
  );

  mp_ram #(.DW(CENT_W), .AW(CIDX_W)) u_ocache (
    .ref_clk (ref_clk),
    .we      (cwe_o),
    .waddr   (cwaddr),
    .wdata   (cwent),
    .raddr   (pa[CIDX_W:1]),
    .rdata   (ord)
  );

  assign init   = st_ff.fsm == S_INIT;
  assign acc    = st_ff.fsm == S_IDLE && req_valid && st_ff.ready
                  && !(req_instr && st_ff.ib_cnt == 3'(IB_DEPTH));
  assign pa     = st_ff.fsm == S_XLAT ? {pte[FRAME_W-1:0], ag_la[PG_OFF_W-1:0]} : ag_la;
  assign ent    = st_ff.instr ? ird : ord;
  assign hit    = ent[CENT_W-1] && ent[CENT_W-2:WORD_W] == st_ff.mar[ADDR_W-1:CIDX_W+1];
  assign cwe_i  = init || (cwe && st_ff.instr);
  assign cwe_o  = init || (cwe && !st_ff.instr);
  assign cwaddr = init ? st_ff.icnt[CIDX_W-1:0] : st_ff.mar[CIDX_W:1];
  assign cwent  = init ? '0 : {1'b1, st_ff.mar[ADDR_W-1:CIDX_W+1], cwdata};

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rsp_valid = 1'b0;
    cwe              = 1'b0;
    cwdata           = st_ff.mdr;
    done             = 1'b0;
    fault            = 1'b0;
    rerr             = 1'b0;
    push             = 1'b0;
    dword            = st_ff.mdr;
    case (st_ff.fsm)
      S_INIT: begin
        nxt_st.icnt = st_ff.icnt + 1'b1;
        if (st_ff.icnt == INIT_LAST) begin
          nxt_st.fsm   = S_IDLE;
          nxt_st.ready = 1'b1;
        end
      end
      S_IDLE: begin
        if (acc) begin
          nxt_st.fsm   = S_AGEN;
          nxt_st.ready = 1'b0;
          nxt_st.instr = req_instr;
          nxt_st.we    = req_we && !req_instr;
          nxt_st.size  = req_size;
          nxt_st.bsel  = req_bsel;
          nxt_st.bitn  = req_bitn;
          nxt_st.wd    = req_wdata;
        end
      end
      S_AGEN: begin
        if (ag_err) begin
          done = 1'b1;
          rerr = 1'b1;
        end else if (ag_xl) begin
          nxt_st.fsm = S_XLAT;
        end else begin
          nxt_st.mar = ag_la;
          nxt_st.fsm = S_LOOK;
        end
      end
      S_XLAT: begin
        if (!pte[FRAME_W]) begin
          done  = 1'b1;
          fault = 1'b1;
        end else begin
          nxt_st.mar = pa;
          nxt_st.fsm = S_LOOK;
        end
      end
      S_LOOK: begin
        if (!hit) begin
          nxt_st.fsm = S_MRD;
        end else if (st_ff.we) begin
          nxt_st.mdr = merge(ent[WORD_W-1:0], st_ff.mar[0], st_ff.size, st_ff.bsel, st_ff.bitn, st_ff.wd);
          nxt_st.fsm = S_MWR;
        end else begin
          nxt_st.mdr = ent[WORD_W-1:0];
          dword      = ent[WORD_W-1:0];
          done       = 1'b1;
        end
      end
      S_MRD: begin
        if (st_ff.mem_req && mem_ack) begin
          nxt_st.mem_req = 1'b0;
          cwe            = 1'b1;
          cwdata         = mem_rdata;
          if (st_ff.we) begin
            nxt_st.mdr = merge(mem_rdata, st_ff.mar[0], st_ff.size, st_ff.bsel, st_ff.bitn, st_ff.wd);
            nxt_st.fsm = S_MWR;
          end else begin
            nxt_st.mdr = mem_rdata;
            dword      = mem_rdata;
            done       = 1'b1;
          end
        end else if (!st_ff.mem_req && !mem_busy) begin
          nxt_st.mem_req = 1'b1;
        end
      end
      S_MWR: begin
        if (st_ff.mem_req && mem_ack) begin
          nxt_st.mem_req = 1'b0;
          nxt_st.mem_we  = 1'b0;
          cwe            = 1'b1;
          done           = 1'b1;
        end else if (!st_ff.mem_req && !mem_busy) begin
          nxt_st.mem_req = 1'b1;
          nxt_st.mem_we  = 1'b1;
        end
      end
      default: nxt_st.fsm = S_INIT;
    endcase
    if (done) begin
      nxt_st.fsm   = S_IDLE;
      nxt_st.ready = 1'b1;
      if (fault || rerr || !st_ff.instr) begin
        nxt_st.rsp_valid = 1'b1;
        nxt_st.rsp_fault = fault;
        nxt_st.rsp_err   = rerr;
        nxt_st.rsp_data  = (fault || rerr) ? '0
                           : pick(dword, st_ff.mar[0], st_ff.size, st_ff.bsel, st_ff.bitn);
      end else begin
        push = 1'b1;
      end
    end
    cnt = st_ff.ib_cnt;
    if (ib_pop && st_ff.ib_valid) begin
      for (int i = 0; i < IB_DEPTH - 1; i++) begin
        nxt_st.ib[i] = st_ff.ib[i+1];
      end
      nxt_st.ib[IB_DEPTH-1] = '0;
      cnt = cnt - 3'h1;
    end
    if (push) begin
      nxt_st.ib[cnt[1:0]] = pick(dword, st_ff.mar[0], st_ff.size, st_ff.bsel, st_ff.bitn);
      cnt = cnt + 3'h1;
    end
    nxt_st.ib_cnt   = cnt;
    nxt_st.ib_valid = cnt != 3'h0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign req_ready     = st_ff.ready;
  assign rsp_valid     = st_ff.rsp_valid;
  assign rsp_data      = st_ff.rsp_data;
  assign rsp_fault     = st_ff.rsp_fault;
  assign rsp_range_err = st_ff.rsp_err;
  assign ib_valid      = st_ff.ib_valid;
  assign ib_data       = st_ff.ib[0];
  assign ib_count      = st_ff.ib_cnt;
  assign mem_req       = st_ff.mem_req;
  assign mem_we        = st_ff.mem_we;
  assign mem_addr      = st_ff.mar;
  assign mem_wdata     = st_ff.mdr;

  a_fault_resp: assert property (@(posedge ref_clk) disable iff (rst)
    st_ff.fsm == S_XLAT && !pte[FRAME_W] |=> rsp_valid && rsp_fault && !mem_req && req_ready)
    else $error("missing page fault response");
  a_fault_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    rsp_valid && rsp_fault |-> !$past(cwe) && !$past(mem_req, 2) && !mem_req)
    else $error("faulting access reached memory or cache");
  a_busy_stall: assert property (@(posedge ref_clk) disable iff (rst)
    (st_ff.fsm == S_MRD || st_ff.fsm == S_MWR) && !mem_req && mem_busy |=> !mem_req)
    else $error("request raised to a busy module");
  a_req_hold: assert property (@(posedge ref_clk) disable iff (rst)
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("handshake dropped before acknowledge");
  a_hit_nomem: assert property (@(posedge ref_clk) disable iff (rst)
    st_ff.fsm == S_LOOK && hit && !st_ff.we |=> !mem_req && req_ready && (rsp_valid || $past(st_ff.instr)))
    else $error("read hit did not finish from cache");
  a_miss_fill: assert property (@(posedge ref_clk) disable iff (rst)
    st_ff.fsm == S_MRD && mem_req && mem_ack |-> cwe && cwent[WORD_W-1:0] == mem_rdata
    && cwent[CENT_W-2:WORD_W] == mem_addr[ADDR_W-1:CIDX_W+1])
    else $error("miss did not fill cache");
  a_split_sect: assert property (@(posedge ref_clk) disable iff (rst)
    !init && (cwe_i || cwe_o) |-> (cwe_i == st_ff.instr) && (cwe_o == !st_ff.instr))
    else $error("cache section used by wrong kind");
  a_ib_bound: assert property (@(posedge ref_clk) disable iff (rst)
    ib_count <= 3'(IB_DEPTH) && ib_valid == (ib_count != 3'h0))
    else $error("prefetch buffer over four");
  a_mon_bypass: assert property (@(posedge ref_clk) disable iff (rst)
    st_ff.fsm == S_AGEN && !ag_err && !ag_xl |=> mem_addr == $past(ag_la))
    else $error("untranslated address altered");
  a_xlate_addr: assert property (@(posedge ref_clk) disable iff (rst)
    st_ff.fsm == S_XLAT && pte[FRAME_W] |=> mem_addr == {$past(pte[FRAME_W-1:0]), $past(ag_la[PG_OFF_W-1:0])})
    else $error("translated address wrong");
endmodule
`default_nettype wire

// [testbench/mp_mem_model.sv]
// mp_mem_model: behavioural self-decoding memory module on the far side of the path
// assumes: mp_pkg compiled first; slow adds ack delay and random busy periods
`timescale 1ns/10ps
`default_nettype none
module mp_mem_model
  import mp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              slow,
  input  wire logic              mem_req,
  input  wire logic              mem_we,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [WORD_W-1:0] mem_wdata,
  output logic      [WORD_W-1:0] mem_rdata,
  output logic                   mem_ack,
  output logic                   mem_busy
);
  logic [WORD_W-1:0] store [int];
  int                wait_n;
  int                wa;
  always @(posedge ref_clk) begin
    wa = int'(mem_addr[19:1]);
    mem_ack   <= 1'b0;
    // data line not held outside an ack
    mem_rdata <= ~mem_rdata;
    mem_busy  <= slow & ($urandom_range(0, 3) == 0);
    if (rst) begin
      mem_rdata <= 48'h0;
      mem_busy  <= 1'b0;
      wait_n    <= 0;
    end else if (mem_req && !mem_ack) begin
      if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end else begin
        if (mem_we)
          store[wa] = mem_wdata;
        mem_rdata <= store.exists(wa) ? store[wa] : {8'hC3, 21'h0, wa[18:0]};
        mem_ack   <= 1'b1;
        wait_n    <= slow ? 3 : 0;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/mp_mem_path_tb_top.sv]
// mp_mem_path_tb_top: random and directed accesses compared with a reference memory
// assumes: mp_mem_model answers the memory link; design assertions run inside
`timescale 1ns/10ps
`default_nettype none
module mp_mem_path_tb_top
  import mp_pkg::*;
;
  logic ref_clk = 0, rst = 1, ext_mode = 1, vm_en = 0, user_mode = 0, slow = 0;
  logic req_valid = 0, req_instr = 0, req_we = 0, ib_pop = 0, pt_we = 0, pt_present = 0;
  mp_src_t  req_src = SRC_CPU;
  mp_ref_t  req_ref = REF_DIRECT;
  mp_size_t req_size = SZ_W48;
  logic [SEC_W-1:0]   req_map = 0;
  logic [ADDR_W-1:0]  req_addr = 0, mem_addr;
  logic [1:0]         req_bsel = 0;
  logic [4:0]         req_bitn = 0;
  logic [WORD_W-1:0]  req_wdata = 0, rsp_data, ib_data, mem_wdata, mem_rdata, got;
  logic [FRAME_W-1:0] pt_page = 0, pt_frame = 0;
  logic               req_ready, rsp_valid, rsp_fault, rsp_range_err, ib_valid, mem_req, mem_we, mem_ack, mem_busy;
  logic [2:0]         ib_count;
  logic               got_fault, got_err;
  int                 n_mismatch = 0, checked = 0, n_memreq = 0;
  logic [WORD_W-1:0]  ref_mem [int];

  mp_mem_path u_dut (.ref_clk, .rst, .ext_mode, .vm_en, .user_mode, .req_valid, .req_src, .req_instr,
    .req_ref, .req_size, .req_we, .req_map, .req_addr, .req_bsel, .req_bitn, .req_wdata, .req_ready,
    .rsp_valid, .rsp_data, .rsp_fault, .rsp_range_err, .ib_pop, .ib_valid, .ib_data, .ib_count, .pt_we,
    .pt_page, .pt_frame, .pt_present, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .mem_busy);
  mp_mem_model u_mem (.ref_clk, .rst, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .mem_busy);

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (mem_req === 1'b1) n_memreq++;

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [WORD_W-1:0] ref_word(input int wa);
    return ref_mem.exists(wa) ? ref_mem[wa] : {8'hC3, 21'h0, wa[18:0]};
  endfunction
  function automatic logic [WORD_W-1:0] ref_read(input logic [19:0] pa, input mp_size_t sz, input int bs, input int bn);
    logic [WORD_W-1:0] w;
    logic [HALF_W-1:0] h;
    w = ref_word(int'(pa[19:1]));
    h = pa[0] ? w[23:0] : w[47:24];
    case (sz)
      SZ_W48:  return w;
      SZ_W24:  return {24'h0, h};
      SZ_BYTE: return {40'h0, h[8*(2-bs)+:8]};
      default: return {47'h0, h[bn]};
    endcase
  endfunction
  task automatic ref_write(input logic [19:0] pa, input mp_size_t sz, input int bs, input int bn,
                           input logic [WORD_W-1:0] wd);
    logic [WORD_W-1:0] w;
    logic [HALF_W-1:0] h;
    w = ref_word(int'(pa[19:1]));
    h = pa[0] ? w[23:0] : w[47:24];
    if (sz == SZ_W24) h = wd[23:0];
    if (sz == SZ_BYTE) h[8*(2-bs)+:8] = wd[7:0];
    if (sz == SZ_BIT) h[bn] = wd[0];
    if (sz == SZ_W48) w = wd;
    else if (pa[0]) w[23:0] = h;
    else w[47:24] = h;
    ref_mem[int'(pa[19:1])] = w;
  endtask
  task automatic mode(input logic e, input logic v, input logic u);
    @(posedge ref_clk);
    ext_mode  <= e;
    vm_en     <= v;
    user_mode <= u;
  endtask
  task automatic pt(input int pg, input int fr, input logic pr);
    @(posedge ref_clk);
    pt_we      <= 1'b1;
    pt_page    <= 10'(pg);
    pt_frame   <= 10'(fr);
    pt_present <= pr;
    @(posedge ref_clk);
    pt_we <= 1'b0;
  endtask
  task automatic acc(input mp_src_t s, input logic ins, input mp_ref_t rf, input mp_size_t sz, input logic we,
                     input logic [4:0] mp, input logic [19:0] a, input int bs, input int bn, input logic [47:0] wd);
    int n;
    @(posedge ref_clk);
    req_src   <= s;
    req_instr <= ins;
    req_ref   <= rf;
    req_size  <= sz;
    req_we    <= we;
    req_map   <= mp;
    req_addr  <= a;
    req_bsel  <= 2'(bs);
    req_bitn  <= 5'(bn);
    req_wdata <= wd;
    req_valid <= 1'b1;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (req_ready !== 1'b1 && n < 2000);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    do begin @(negedge ref_clk); n++; end while (rsp_valid !== 1'b1 && !(ins && req_ready === 1'b1) && n < 4000);
    if (n >= 4000) begin
      n_mismatch++;
      final_report();
    end
    got       = rsp_data;
    got_fault = rsp_fault;
    got_err   = rsp_range_err;
  endtask

  initial begin
    logic [19:0] a;
    mp_size_t    sz;
    int          bs, bn, mr;
    logic [47:0] wd;
    void'($urandom(55));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      // odd passes stall the memory with busy and slow acks
      slow = i[0];
      a  = 20'($urandom);
      sz = mp_size_t'(i % 4);
      bs = $urandom_range(0, 2);
      bn = $urandom_range(0, 23);
      wd = {$urandom, $urandom};
      acc(SRC_CPU, 0, REF_DIRECT, sz, 0, 0, a, bs, bn, 48'h0);
      chk("miss read", got, ref_read(a, sz, bs, bn));
      acc(SRC_CPU, 0, REF_DIRECT, sz, 1, 0, a, bs, bn, wd);
      ref_write(a, sz, bs, bn, wd);
      mr = n_memreq;
      acc(SRC_CPU, 0, REF_DIRECT, sz, 0, 0, a, bs, bn, 48'h0);
      chk("hit read", got, ref_read(a, sz, bs, bn));
      chk("hit memory cycles", 48'(n_memreq), 48'(mr));
    end
    $display("test read write done");
    mode(0, 0, 0);
    acc(SRC_CPU, 0, REF_DIRECT, SZ_W48, 0, 5'h3, 20'h00010, 0, 0, 48'h0);
    chk("section read", got, ref_read(20'h18010, SZ_W48, 0, 0));
    acc(SRC_CPU, 0, REF_DIRECT, SZ_W48, 0, 5'h3, 20'h08000, 0, 0, 48'h0);
    chk("direct limit", 48'(got_err), 48'h1);
    acc(SRC_CPU, 0, REF_INDIRECT, SZ_W48, 0, 0, 20'h3FFFF, 0, 0, 48'h0);
    chk("indirect edge", got, ref_read(20'h3FFFF, SZ_W48, 0, 0));
    chk("indirect edge err", 48'(got_err), 48'h0);
    acc(SRC_CPU, 0, REF_INDIRECT, SZ_W48, 0, 0, 20'h40000, 0, 0, 48'h0);
    chk("indirect limit", 48'(got_err), 48'h1);
    acc(SRC_CPU, 1, REF_DIRECT, SZ_W48, 0, 0, 20'h10000, 0, 0, 48'h0);
    chk("code limit", 48'(got_err), 48'h1);
    $display("test address modes done");
    mode(1, 1, 1);
    pt(2, 5, 1);
    pt(3, 9, 0);
    acc(SRC_CPU, 0, REF_DIRECT, SZ_W48, 0, 0, 20'h00807, 0, 0, 48'h0);
    chk("translated read", got, ref_read(20'h01407, SZ_W48, 0, 0));
    mr = n_memreq;
    acc(SRC_CPU, 0, REF_DIRECT, SZ_W48, 1, 0, 20'h00C07, 0, 0, 48'h123456789ABC);
    chk("page fault", 48'(got_fault), 48'h1);
    chk("fault memory cycles", 48'(n_memreq), 48'(mr));
    acc(SRC_BLK, 0, REF_DIRECT, SZ_W48, 0, 0, 20'h00C07, 0, 0, 48'h0);
    chk("channel read", got, ref_read(20'h00C07, SZ_W48, 0, 0));
    chk("channel fault", 48'(got_fault), 48'h0);
    mode(1, 1, 0);
    acc(SRC_CPU, 0, REF_DIRECT, SZ_W48, 0, 0, 20'h02407, 0, 0, 48'h0);
    chk("monitor read", got, ref_read(20'h02407, SZ_W48, 0, 0));
    chk("monitor fault", 48'(got_fault), 48'h0);
    $display("test paging done");
    for (int i = 0; i < 4; i++)
      acc(SRC_CPU, 1, REF_DIRECT, SZ_W48, 0, 0, 20'hF0000 + 20'(2 * i), 0, 0, 48'h0);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    repeat (5) @(posedge ref_clk);
    req_valid <= 1'b0;
    @(negedge ref_clk);
    chk("buffer full", 48'(ib_count), 48'h4);
    for (int i = 0; i < 4; i++) begin
      chk("fetched word", ib_data, ref_word(int'(20'hF0000 + 20'(2 * i)) >> 1));
      @(posedge ref_clk);
      ib_pop <= 1'b1;
      @(posedge ref_clk);
      ib_pop <= 1'b0;
      @(negedge ref_clk);
    end
    chk("buffer empty", 48'(ib_count), 48'h0);
    chk("buffer valid", 48'(ib_valid), 48'h0);
    $display("test prefetch done");
    final_report();
  end
endmodule
`default_nettype wire
